// File: rtl/iagg_top.sv
`include "iagg_consts.svh"

module iagg_top
   import iagg_pkg::*;
(
   input wire logic mclk, // 125 MHz core clock
   input wire logic rst, // synchronous reset, active high
   input wire iagg_bus_req_t bus_req, // peripheral bus request
   output logic [31:0] bus_rdata, // read data, one cycle after rd
   output logic bus_rvalid, // read data valid pulse
   input wire iagg_pins_t pins, // asynchronous event pins
   input wire iagg_tp_evt_t tp_evt, // same-clock interrupt pulses
   input wire logic [1:0] group_enable, // [0] gpio group, [1] timer/power group
   output logic gpio_group_irq, // gated gpio group request
   output logic timer_power_group_irq, // gated timer/power group request
   output logic wake_request // any enabled wake-capable event
);

   // synchroniser stages; stage one is read only by stage two
   // two stages are the price of pins that do not run on mclk:
   // a pin event shows up about three edges late, but all bits
   // of one pin pass the same path, so no event is split
   logic [20:0] sync1_q, sync1_d;
   logic [20:0] sync2_q, sync2_d;
   logic [20:0] prev_q, prev_d; // last synced level for edge detect

   // registers
   // sources and enables are whole words so the read mux stays simple;
   // unimplemented bits are masked on every write and never hold a one
   logic [31:0] gpio_src_q, gpio_src_d;
   logic [31:0] gpio_en_q, gpio_en_d;
   logic gpio_normalize_helper_bit_q, gpio_normalize_helper_bit_d;
   logic [31:0] tp_src_q, tp_src_d;
   logic [31:0] tp_en_q, tp_en_d;
   logic tp_normalize_helper_bit_q, tp_normalize_helper_bit_d;
   logic [31:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;

   // combinational helpers
   // all of these settle within one mclk period
   logic [15:0] gpio_edge; // rising edges of gpio pins
   logic ovrd_edge; // rising edge of override input
   logic [3:0] vci_edge; // assertion (falling) of wake-control pins
   logic [31:0] gpio_set, tp_set; // event set vectors
   logic [31:0] gpio_res, tp_res; // result words incl. storage bit

   // write-one-to-clear with set priority, masked to implemented bits
   // a set in the clear cycle wins, so an event that lands while software
   // acknowledges the previous one is never lost
   function automatic logic [31:0] w1c_next(input logic [31:0] cur, input logic [31:0] set,
                                            input logic clr_wr, input logic [31:0] wdata,
                                            input logic [31:0] mask);
      logic [31:0] clr;
      clr = clr_wr ? wdata : 32'h0000_0000;
      return ((cur & ~clr) | set) & mask;
   endfunction

   // address match for a write or read strobe
   // exact compare: the registers have no aliases in the map
   function automatic logic hit(input logic strobe, input logic [9:0] addr, input logic [9:0] ofs);
      return strobe && (addr == ofs);
   endfunction

   // pin synchroniser and edge history
   // stage one may hold a metastable sample for one period
   always_comb begin
      sync1_d = {pins.gpio, pins.override_in, pins.wake_ctl_in_n};
      sync2_d = sync1_q;
      prev_d = sync2_q;
   end

   // the pins idle safely after reset: gpio low, override low, vci high
   // history loads the idle levels, not zero, so the active-low
   // wake-control pins raise no false event as reset lets go
   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1_q <= `IAGG_PIN_IDLE; // idle levels
         sync2_q <= `IAGG_PIN_IDLE;
         prev_q <= `IAGG_PIN_IDLE;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q <= prev_d;
      end
   end

   // event detection; edges so a held pin raises one event only
   // gpio and override count on the rising edge; the wake-control
   // pins are active low, so their falling edge is the event
   always_comb begin
      gpio_edge = sync2_q[`IAGG_SYNC_GPIO] & ~prev_q[`IAGG_SYNC_GPIO];
      ovrd_edge = sync2_q[`IAGG_SYNC_OVRD] & ~prev_q[`IAGG_SYNC_OVRD];
      vci_edge = ~sync2_q[`IAGG_SYNC_VCI] & prev_q[`IAGG_SYNC_VCI];
      gpio_set = {16'h0000, gpio_edge};

      // same-clock pulses need no synchroniser; a held pulse keeps
      // setting its bit, which the set-wins clear tolerates
      tp_set = 32'h0000_0000;
      tp_set[`IAGG_TP_TIMER_LSB +: 4] = tp_evt.timer_irq;
      tp_set[`IAGG_TP_PFAIL_BIT] = tp_evt.power_fail_irq;
      tp_set[`IAGG_TP_ALARM_BIT] = tp_evt.weekly_alarm_irq;
      tp_set[`IAGG_TP_OVRD_BIT] = ovrd_edge;
      tp_set[`IAGG_TP_VCI_LSB +: 4] = vci_edge;
   end

   // register next-state: sources, enables, storage bits
   // a read and a write in one cycle both act; the read sees the old word
   always_comb begin
      gpio_src_d = w1c_next(gpio_src_q, gpio_set, hit(bus_req.wr, bus_req.addr, `IAGG_OFS_GPIO_SRC),
                            bus_req.wdata, `IAGG_GPIO_MASK);
      tp_src_d = w1c_next(tp_src_q, tp_set, hit(bus_req.wr, bus_req.addr, `IAGG_OFS_TP_SRC),
                          bus_req.wdata, `IAGG_TP_MASK);
      gpio_en_d = gpio_en_q;
      tp_en_d = tp_en_q;
      gpio_normalize_helper_bit_d = gpio_normalize_helper_bit_q;
      tp_normalize_helper_bit_d = tp_normalize_helper_bit_q;
      // enables keep only the bits that have a source behind them
      if (hit(bus_req.wr, bus_req.addr, `IAGG_OFS_GPIO_EN)) begin
         gpio_en_d = bus_req.wdata & `IAGG_GPIO_MASK;
      end
      if (hit(bus_req.wr, bus_req.addr, `IAGG_OFS_TP_EN)) begin
         tp_en_d = bus_req.wdata & `IAGG_TP_MASK;
      end
      // result bits 30:0 ignore writes; only bit 31 stores
      if (hit(bus_req.wr, bus_req.addr, `IAGG_OFS_GPIO_RES)) begin
         gpio_normalize_helper_bit_d = bus_req.wdata[`IAGG_NORMALIZE_HELPER_BIT_BIT];
      end
      if (hit(bus_req.wr, bus_req.addr, `IAGG_OFS_TP_RES)) begin
         tp_normalize_helper_bit_d = bus_req.wdata[`IAGG_NORMALIZE_HELPER_BIT_BIT];
      end
   end

   // register state, all cleared by system reset
   // reset is synchronous, so mclk must run while it is held
   always_ff @(posedge mclk) begin
      if (rst) begin
         gpio_src_q <= `IAGG_RST_WORD;
         gpio_en_q <= `IAGG_RST_WORD;
         gpio_normalize_helper_bit_q <= 1'b0;
         tp_src_q <= `IAGG_RST_WORD;
         tp_en_q <= `IAGG_RST_WORD;
         tp_normalize_helper_bit_q <= 1'b0;
      end else begin
         gpio_src_q <= gpio_src_d;
         gpio_en_q <= gpio_en_d;
         gpio_normalize_helper_bit_q <= gpio_normalize_helper_bit_d;
         tp_src_q <= tp_src_d;
         tp_en_q <= tp_en_d;
         tp_normalize_helper_bit_q <= tp_normalize_helper_bit_d;
      end
   end

   // results and gated requests
   // results are not stored: they follow source and enable in the
   // same cycle, so a clear drops the request one cycle after the write
   always_comb begin
      gpio_res = {gpio_normalize_helper_bit_q, gpio_src_q[`IAGG_EVT_BITS] & gpio_en_q[`IAGG_EVT_BITS]};
      tp_res = {tp_normalize_helper_bit_q, tp_src_q[`IAGG_EVT_BITS] & tp_en_q[`IAGG_EVT_BITS]};

      // bit 31 is storage only and never requests
      gpio_group_irq = group_enable[0] & (|gpio_res[`IAGG_EVT_BITS]);
      timer_power_group_irq = group_enable[1] & (|tp_res[`IAGG_EVT_BITS]);
      // wake ignores the group gate so a sleeping core can still be woken
      wake_request = (|(gpio_src_q & gpio_en_q & `IAGG_GPIO_WAKE_MASK))
                   | (|(tp_src_q & tp_en_q & `IAGG_TP_WAKE_MASK));
   end

   // read mux; reserved bits and unmapped addresses read zero
   // an unmapped read is still answered, so the core never waits;
   // the cost is that a wrong address is not flagged
   always_comb begin
      rvalid_d = bus_req.rd;
      rdata_d = 32'h0000_0000;
      if (bus_req.rd) begin
         case (bus_req.addr)
            `IAGG_OFS_GPIO_SRC: rdata_d = gpio_src_q;
            `IAGG_OFS_GPIO_EN: rdata_d = gpio_en_q;
            `IAGG_OFS_GPIO_RES: rdata_d = gpio_res;
            `IAGG_OFS_TP_SRC: rdata_d = tp_src_q;
            `IAGG_OFS_TP_EN: rdata_d = tp_en_q;
            `IAGG_OFS_TP_RES: rdata_d = tp_res;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // read data from flops
   // data returns to zero when no read was made in the previous cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_q <= `IAGG_RST_WORD;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // outputs straight from flops, no logic after the register
   assign bus_rdata = rdata_q;
   assign bus_rvalid = rvalid_q;

endmodule

// File: pkg/iagg_consts.svh
`ifndef IAGG_CONSTS_SVH
`define IAGG_CONSTS_SVH

// register offsets on the peripheral bus (byte addresses)
`define IAGG_OFS_GPIO_SRC 10'h118
`define IAGG_OFS_GPIO_EN 10'h11C
`define IAGG_OFS_GPIO_RES 10'h120
`define IAGG_OFS_TP_SRC 10'h12C
`define IAGG_OFS_TP_EN 10'h130
`define IAGG_OFS_TP_RES 10'h134

// reset values
`define IAGG_RST_WORD 32'h0000_0000

// implemented and wake-capable bit masks per group
`define IAGG_GPIO_MASK 32'h0000_FFFF
`define IAGG_TP_MASK 32'h0000_1FAF
`define IAGG_TP_WAKE_MASK 32'h0000_1F80
`define IAGG_GPIO_WAKE_MASK 32'h0000_FFFF

// field positions
`define IAGG_NORMALIZE_HELPER_BIT_BIT 31
`define IAGG_TP_TIMER_LSB 0
`define IAGG_TP_PFAIL_BIT 5
`define IAGG_TP_ALARM_BIT 7
`define IAGG_TP_OVRD_BIT 8
`define IAGG_TP_VCI_LSB 9

// synchroniser vector layout, pin idle levels and result event bits
`define IAGG_PIN_IDLE 21'h0_000F
`define IAGG_SYNC_GPIO 20:5
`define IAGG_SYNC_OVRD 4
`define IAGG_SYNC_VCI 3:0
`define IAGG_EVT_BITS 30:0

`endif

// File: pkg/iagg_pkg.sv
package iagg_pkg;

   // one register bus request from the processor core
   typedef struct packed {
      logic [9:0] addr; // byte address
      logic wr; // write strobe, one cycle
      logic rd; // read strobe, one cycle
      logic [31:0] wdata; // write data
   } iagg_bus_req_t;

   // same-clock interrupt pulses of the timer/power group
   typedef struct packed {
      logic [3:0] timer_irq; // counter/timer 3..0
      logic power_fail_irq; // power-fail status register
      logic weekly_alarm_irq; // week alarm terminal count
   } iagg_tp_evt_t;

   // raw pins from outside the clock domain
   typedef struct packed {
      logic [15:0] gpio; // gpio 215..200 event pins
      logic override_in; // wake-control override input, active high
      logic [3:0] wake_ctl_in_n; // wake-control inputs 3..0, active low
   } iagg_pins_t;

endpackage

// File: sim/iagg_props.sv
module iagg_props
   import iagg_pkg::*;
(
   input wire logic mclk, // core clock
   input wire logic rst, // sync reset
   input wire iagg_bus_req_t bus_req, // bus request
   input wire logic [31:0] bus_rdata, // read data
   input wire logic bus_rvalid, // read valid pulse
   input wire iagg_tp_evt_t tp_evt, // timer/power pulses
   input wire logic [1:0] group_enable, // group gates
   input wire logic gpio_group_irq, // gpio request
   input wire logic timer_power_group_irq // timer/power request
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic mapped; // address hits one of the six registers
   assign mapped = bus_req.addr inside {10'h118, 10'h11C, 10'h120, 10'h12C, 10'h130, 10'h134};
   // alarm pulse, then a read of the timer/power source
   sequence alarm_then_rd;
      tp_evt.weekly_alarm_irq ##1 (bus_req.rd && bus_req.addr == 10'h12C);
   endsequence
   a_rd_answered: assert property (bus_req.rd |=> bus_rvalid) else $error("read not answered");
   a_no_stray_valid: assert property (!bus_req.rd |=> !bus_rvalid) else $error("stray valid");
   a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 32'h0000_0000) else $error("rdata idle");
   a_unmapped_zero: assert property (bus_req.rd && !mapped |=> bus_rdata == 32'h0000_0000)
      else $error("unmapped read nonzero");
   a_tp_reserved: assert property (bus_req.rd && bus_req.addr == 10'h12C |=>
      (bus_rdata & 32'h7FFF_E050) == 32'h0000_0000) else $error("reserved bit set");
   a_gpio_gated: assert property (!group_enable[0] |-> !gpio_group_irq) else $error("gpio not gated");
   a_tp_gated: assert property (!group_enable[1] |-> !timer_power_group_irq) else $error("tp not gated");
   a_alarm_latched: assert property (alarm_then_rd |=> bus_rdata[7]) else $error("alarm lost");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> !bus_rvalid && !gpio_group_irq
      && !timer_power_group_irq) else $error("not quiet after reset");
endmodule

// File: sim/iagg_cpu_model.sv
module iagg_cpu_model
   import iagg_pkg::*;
(
   input wire logic mclk, // core clock
   output iagg_bus_req_t bus_req // request to the aggregator
);
   timeunit 1ns;
   timeprecision 1ps;
   initial bus_req = '0;
   // one-cycle strobe, taken at the edge after launch
   task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus_req <= '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge mclk);
      // released lines scrambled so no stale value is trusted
      bus_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask
endmodule

// File: sim/tb.sv
module tb
   import iagg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst = 1'b1, bus_rvalid, gpio_group_irq, timer_power_group_irq, wake_request;
   logic [31:0] bus_rdata, seed; // read data, xorshift state
   logic [15:0] v; // random gpio pattern
   logic [1:0] group_enable; // group gates
   iagg_bus_req_t bus_req; // from the core model
   iagg_pins_t pins; // event pins
   iagg_tp_evt_t tp_evt; // timer/power pulses
   logic [31:0] q[$]; // expected read data, oldest first
   int miscompares = 0, n_compared = 0;
   logic [9:0] ofs [7] = '{10'h118, 10'h11C, 10'h120, 10'h12C, 10'h130, 10'h134, 10'h200};
   iagg_cpu_model cpu (.mclk(mclk), .bus_req(bus_req));
   iagg_top uut (.mclk(mclk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
      .pins(pins), .tp_evt(tp_evt), .group_enable(group_enable), .gpio_group_irq(gpio_group_irq),
      .timer_power_group_irq(timer_power_group_irq), .wake_request(wake_request));
   initial forever #4 mclk = ~mclk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_rd({31'h0, got}, {31'h0, exp});
   endtask
   // note the expectation, then issue the read
   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      q.push_back(e);
      cpu.xfer(1'b0, a, 32'h0000_0000);
   endtask
   task automatic end_sim();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // watcher: each valid pulse takes the oldest note
   always @(posedge mclk) begin
      if (bus_rvalid === 1'b1) begin
         if (q.size() == 0) chk_rd(bus_rdata, 32'hDEAD_BEEF);
         else chk_rd(bus_rdata, q.pop_front());
      end
   end
   initial begin
      pins = '0;
      pins.wake_ctl_in_n = 4'hF;
      tp_evt = '0;
      group_enable = 2'b11;
      seed = 32'h0000_ed84;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      foreach (ofs[i]) rd(ofs[i], 32'h0000_0000);
      $display("test reset done");
      cpu.xfer(1'b1, 10'h11C, 32'hFFFF_FFFF);
      rd(10'h11C, 32'h0000_FFFF);
      cpu.xfer(1'b1, 10'h120, 32'hFFFF_FFFF);
      rd(10'h120, 32'h8000_0000);
      seed = xs(seed);
      v = seed[15:0] | 16'h0001;
      pins.gpio <= v;
      repeat (5) @(posedge mclk);
      rd(10'h118, {16'h0000, v});
      rd(10'h120, {16'h8000, v});
      chk_bit(gpio_group_irq, 1'b1);
      group_enable <= 2'b10;
      @(posedge mclk);
      #1 chk_bit(gpio_group_irq, 1'b0);
      cpu.xfer(1'b1, 10'h118, {16'hFFFF, v & 16'h00FF});
      rd(10'h118, {16'h0000, v & 16'hFF00});
      cpu.xfer(1'b1, 10'h118, 32'hFFFF_FFFF);
      rd(10'h118, 32'h0000_0000);
      $display("test gpio done");
      cpu.xfer(1'b1, 10'h130, 32'hFFFF_FFFF);
      rd(10'h130, 32'h0000_1FAF);
      tp_evt <= '1;
      pins.override_in <= 1'b1;
      pins.wake_ctl_in_n <= 4'h0;
      @(posedge mclk);
      tp_evt <= '0;
      repeat (5) @(posedge mclk);
      rd(10'h12C, 32'h0000_1FAF);
      chk_bit(wake_request, 1'b1);
      chk_bit(timer_power_group_irq, 1'b1);
      @(posedge mclk);
      tp_evt.timer_irq <= 4'h1;
      cpu.xfer(1'b1, 10'h12C, 32'hFFFF_FFFF);
      tp_evt <= '0;
      rd(10'h12C, 32'h0000_0001);
      rd(10'h134, 32'h0000_0001);
      chk_bit(wake_request, 1'b0);
      tp_evt.weekly_alarm_irq <= 1'b1;
      rd(10'h12C, 32'h0000_0081);
      tp_evt <= '0;
      group_enable <= 2'b00;
      $display("test timer power done");
      for (int i = 0; i < 20 && q.size() != 0; i++) @(posedge mclk);
      if (q.size() != 0) miscompares++;
      end_sim();
   end
endmodule
bind iagg_top iagg_props u_props (.mclk(mclk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .bus_rvalid(bus_rvalid), .tp_evt(tp_evt), .group_enable(group_enable), .gpio_group_irq(gpio_group_irq),
   .timer_power_group_irq(timer_power_group_irq));
